// ### hdl/pse_mode_seq.v
// Top of the four-port PSE mode sequencer: serial register slave,
// register file and four port sequencers.
// Assumes scl/sda, the mode strap and address pins are asynchronous;
// fault inputs and measurements come from logic on core_clk_i.
//
// Function
// - Each port holds its own mode: manual, semiauto, auto or shutdown.
// - After reset all ports shut down if strap low, auto if high.
// - Mode register is writable any time, whatever the strap level.
// - Manual port idles; runs one cycle on command; posts results to status.
// - Manual power triggers switch power at once, ignoring detection outcome.
// - Semiauto loops detect and classify; powers only on host trigger.
// - Auto classifies after valid detection, then powers whatever the class.
// - Shutdown: no detect, no power; events, status and detect/class enables held zero.
// - Startup or overcurrent timeout fault removes power in every mode.
// - Disconnect event removes power when disconnect enable is set.
// - Host power-off trigger turns a port off in any mode.
// - Reset pin or reset-all bit turns ports off and reloads defaults.
// - Detection applies two currents, stores first point, uses difference.
// - Valid resistance window reports good code; others own codes.
// - Each detection point takes 100 ms; full cycle within 230 ms.
// - Manual detection waits for restart trigger, runs once, then idles.
// - Semiauto repeats detection every 320 ms, 330 ms when it classifies, refreshing status each time.
// - Detection inhibited in shutdown, while powered or detect disabled.
// - Current bands map to classes 0 to 4; class 4 powered as 0.
// - Classification measures current at 18 V and stores the class code.
// - Semiauto/auto classify right after good detection; manual on command.
// - Classification inhibited in shutdown, while powered or class disabled.
// - Trigger registers act on ones only and read back as zero.
// - Restart trigger: low nibble detection, high nibble classification.
// - Power trigger: low nibble sets power enable, high nibble clears.
`timescale 1ns/1ps
`include "pse_defs.vh"
module pse_mode_seq #(
  parameter [`CNT_W-1:0] POINT_CYC = `DET_POINT_MS * `CLK_PER_MS,
  parameter [`CNT_W-1:0] GAP_CYC   = (`DET_REPEAT_MS - 2 * `DET_POINT_MS) * `CLK_PER_MS,
  parameter [`CNT_W-1:0] CLASS_CYC = `CLASS_MS * `CLK_PER_MS
) (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire        ce_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output reg         sda_oe_o,
  input  wire [3:0]  bus_addr_i,
  input  wire        mode_strap_i,
  input  wire [3:0]  startup_timeout_i,
  input  wire [3:0]  overcurrent_timeout_i,
  input  wire [3:0]  disconnect_i,
  input  wire [39:0] meas_volt_i,
  input  wire [23:0] meas_curr_i,
  output wire [3:0]  port_probe_pin_o,
  output wire [3:0]  probe_step_o,
  output wire [3:0]  class_drive_o,
  output wire [3:0]  power_on_o
);
  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_ADDR = 3'h1;
  localparam [2:0] I_PTR  = 3'h2;
  localparam [2:0] I_WDAT = 3'h3;
  localparam [2:0] I_ACK  = 3'h4;
  localparam [2:0] I_RDAT = 3'h5;
  localparam [2:0] I_RACK = 3'h6;

  wire       s_scl;
  wire       s_sda;
  wire       s_strap;
  wire [3:0] s_addr;
  reg        scl_q;
  reg        sda_q;

  reg        soft_rst;
  wire       srst = ~rst_b_i | soft_rst;

  reg [2:0]  ist;
  reg [2:0]  ack_to;
  reg [3:0]  bitc;
  reg [7:0]  sh;
  reg [7:0]  ptr;
  reg        nack;
  reg        wr_stb;
  reg [7:0]  wr_dat;
  reg [7:0]  rd_data;

  reg [7:0]  mode_reg;
  reg [7:0]  dc_en;
  reg [3:0]  disc_en;
  reg [3:0]  det_evt;
  reg [3:0]  cls_evt;
  reg [3:0]  tst_evt;
  reg [3:0]  icut_evt;
  reg [3:0]  disc_evt;
  reg [1:0]  load_cnt;

  wire [3:0] shut_v;
  wire [3:0] det_done_v;
  wire [3:0] cls_done_v;
  wire [11:0] det_code_v;
  wire [11:0] cls_code_v;

  // Trigger decode: only ones act
  wire wr_restart = wr_stb & (ptr == `OFS_DC_RESTART);
  wire wr_pwr     = wr_stb & (ptr == `OFS_PWR_TRIG);
  wire wr_rst     = wr_stb & (ptr == `OFS_RST_TRIG);
  wire [3:0] det_go   = wr_restart ? wr_dat[3:0] : 4'h0;
  wire [3:0] cls_go   = wr_restart ? wr_dat[7:4] : 4'h0;
  wire [3:0] pwr_on   = wr_pwr ? wr_dat[3:0] : 4'h0;
  wire [3:0] pwr_off  = wr_pwr ? wr_dat[7:4] : 4'h0;
  wire [3:0] port_rst = wr_rst ? wr_dat[3:0] : 4'h0;
  wire [3:0] clr_port = shut_v | port_rst;
  wire [3:0] fault_v  = startup_timeout_i | overcurrent_timeout_i
                        | (disconnect_i & disc_en);

  wire i2c_start = s_scl & scl_q & sda_q & ~s_sda;
  wire i2c_stop  = s_scl & scl_q & ~sda_q & s_sda;
  wire scl_rise  = s_scl & ~scl_q;
  wire scl_fall  = ~s_scl & scl_q;

  assign sda_o = 1'b0;

  sync2 #(
    .W (7)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .ce_i       (ce_i),
    .async_i    ({scl_i, sda_i, mode_strap_i, bus_addr_i}),
    .sync_o     ({s_scl, s_sda, s_strap, s_addr})
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_port
      assign shut_v[g] = (mode_reg[2*g+1:2*g] == `MODE_SHUT);
      // Separate instance per port keeps faults local
      port_seq #(
        .POINT_CYC (POINT_CYC),
        .GAP_CYC   (GAP_CYC),
        .CLASS_CYC (CLASS_CYC)
      ) u_seq (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (~srst),
        .ce_i          (ce_i),
        .mode_i        (mode_reg[2*g+1:2*g]),
        .det_en_i      (dc_en[g] | det_go[g]),
        .cls_en_i      (dc_en[g+4] | cls_go[g]),
        .det_go_i      (det_go[g]),
        .cls_go_i      (cls_go[g]),
        .on_i          (pwr_on[g] & ~shut_v[g]),
        .off_i         (pwr_off[g] | port_rst[g]),
        .fault_i       (fault_v[g]),
        .clear_i       (clr_port[g]),
        .volt_i        (meas_volt_i[10*g+9:10*g]),
        .curr_i        (meas_curr_i[6*g+5:6*g]),
        .probe_o       (port_probe_pin_o[g]),
        .probe_step_o  (probe_step_o[g]),
        .class_drive_o (class_drive_o[g]),
        .power_o       (power_on_o[g]),
        .det_code_o    (det_code_v[3*g+2:3*g]),
        .cls_code_o    (cls_code_v[3*g+2:3*g]),
        .det_done_o    (det_done_v[g]),
        .cls_done_o    (cls_done_v[g])
      );
    end
  endgenerate

  // Read data; trigger and unmapped offsets return zero
  always @*
  begin
    rd_data = 8'h00;
    case (ptr)
      `OFS_DET_EVT:  rd_data = {cls_evt, det_evt};
      `OFS_FLT_EVT:  rd_data = {icut_evt, tst_evt};
      `OFS_DISC_EVT: rd_data = {4'h0, disc_evt};
      `OFS_PWR_STAT: rd_data = {4'h0, power_on_o};
      `OFS_MODE:     rd_data = mode_reg;
      `OFS_DISC_EN:  rd_data = {4'h0, disc_en};
      `OFS_DC_EN:    rd_data = dc_en;
      default:
      begin
        if (ptr >= `OFS_STAT0 && ptr <= `OFS_STAT3)
          rd_data = {1'b0, cls_code_v[3*ptr[1:0]+:3], 1'b0, det_code_v[3*ptr[1:0]+:3]};
      end
    endcase
  end

  // Reset-all lasts one cycle and restarts everything except this flop, which only the pin resets, and the synchroniser, which nothing resets
  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      soft_rst <= 1'b0;
    else if (ce_i)
      soft_rst <= ~soft_rst & wr_rst & wr_dat[`RST_ALL_BIT];
  end

  // Serial slave: start/stop win over any byte in progress
  always @(posedge core_clk_i)
  begin
    if (srst)
    begin
      ist      <= I_IDLE;
      ack_to   <= I_IDLE;
      bitc     <= 4'h0;
      sh       <= 8'h00;
      ptr      <= 8'h00;
      nack     <= 1'b0;
      wr_stb   <= 1'b0;
      wr_dat   <= 8'h00;
      sda_oe_o <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_q  <= s_scl;
      sda_q  <= s_sda;
      wr_stb <= 1'b0;
      if (i2c_start)
      begin
        ist      <= I_ADDR;
        bitc     <= 4'h0;
        sda_oe_o <= 1'b0;
      end
      else if (i2c_stop)
      begin
        ist      <= I_IDLE;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (ist)
          I_ADDR, I_PTR, I_WDAT:
          begin
            if (scl_rise)
            begin
              sh   <= {sh[6:0], s_sda};
              bitc <= bitc + 1'b1;
            end
            else if (scl_fall && bitc == 4'h8)
            begin
              bitc <= 4'h0;
              ist  <= I_ACK;
              if (ist == I_ADDR)
              begin
                if (sh[7:1] == {`DEV_ADDR_HI, s_addr})
                begin
                  sda_oe_o <= 1'b1;
                  ack_to   <= sh[0] ? I_RDAT : I_PTR;
                end
                else
                  ist <= I_IDLE;
              end
              else if (ist == I_PTR)
              begin
                ptr      <= sh;
                sda_oe_o <= 1'b1;
                ack_to   <= I_WDAT;
              end
              else
              begin
                wr_stb   <= 1'b1;
                wr_dat   <= sh;
                sda_oe_o <= 1'b1;
                ack_to   <= I_WDAT;
              end
            end
          end
          I_ACK:
          begin
            if (scl_fall)
            begin
              ist <= ack_to;
              if (ack_to == I_RDAT)
              begin
                sh       <= rd_data;
                sda_oe_o <= ~rd_data[7];
              end
              else
                sda_oe_o <= 1'b0;
            end
          end
          I_RDAT:
          begin
            if (scl_rise)
              bitc <= bitc + 1'b1;
            else if (scl_fall)
            begin
              if (bitc == 4'h8)
              begin
                bitc     <= 4'h0;
                sda_oe_o <= 1'b0;
                ist      <= I_RACK;
              end
              else
              begin
                sh       <= {sh[6:0], 1'b0};
                sda_oe_o <= ~sh[6];
              end
            end
          end
          I_RACK:
          begin
            if (scl_rise)
              nack <= s_sda;
            else if (scl_fall)
            begin
              if (nack)
                ist <= I_IDLE;
              else
              begin
                sh       <= rd_data;
                sda_oe_o <= ~rd_data[7];
                ist      <= I_RDAT;
              end
            end
          end
          default:
            ist <= I_IDLE;
        endcase
      end
    end
  end

  // Register file; strap defaults load once the synchroniser has settled
  always @(posedge core_clk_i)
  begin
    if (srst)
    begin
      mode_reg <= {4{`MODE_SHUT}};
      dc_en    <= 8'h00;
      disc_en  <= 4'h0;
      det_evt  <= 4'h0;
      cls_evt  <= 4'h0;
      tst_evt  <= 4'h0;
      icut_evt <= 4'h0;
      disc_evt <= 4'h0;
      load_cnt <= `LOAD_DLY;
    end
    else if (ce_i)
    begin
      if (load_cnt != 2'h0)
        load_cnt <= load_cnt - 1'b1;
      if (load_cnt == 2'h1 && s_strap)
      begin
        mode_reg <= `MODE_ALL_AUTO;
        dc_en    <= `DC_EN_ALL;
        disc_en  <= `DISC_EN_ALL;
      end
      else
      begin
        if (wr_stb && ptr == `OFS_MODE)
          mode_reg <= wr_dat;
        if (wr_stb && ptr == `OFS_DISC_EN)
          disc_en <= wr_dat[3:0];
        if (wr_stb && ptr == `OFS_DC_EN)
          dc_en <= wr_dat & ~{clr_port, clr_port};
        else
          dc_en <= (dc_en | (wr_restart ? wr_dat : 8'h00)) & ~{clr_port, clr_port};
      end
      // Hardware set wins over a write-one clear in the same cycle
      det_evt  <= ((det_evt & ~((wr_stb && ptr == `OFS_DET_EVT) ? wr_dat[3:0] : 4'h0))
                   | det_done_v) & ~clr_port;
      cls_evt  <= ((cls_evt & ~((wr_stb && ptr == `OFS_DET_EVT) ? wr_dat[7:4] : 4'h0))
                   | cls_done_v) & ~clr_port;
      tst_evt  <= ((tst_evt & ~((wr_stb && ptr == `OFS_FLT_EVT) ? wr_dat[3:0] : 4'h0))
                   | startup_timeout_i) & ~clr_port;
      icut_evt <= ((icut_evt & ~((wr_stb && ptr == `OFS_FLT_EVT) ? wr_dat[7:4] : 4'h0))
                   | overcurrent_timeout_i) & ~clr_port;
      disc_evt <= ((disc_evt & ~((wr_stb && ptr == `OFS_DISC_EVT) ? wr_dat[3:0] : 4'h0))
                   | disconnect_i) & ~clr_port;
    end
  end
endmodule // pse_mode_seq

// ### hdl/pse_defs.vh
// Shared constants for the four-port PSE mode sequencer.
// Assumes a 200 MHz core clock; included by the top and port sequencer files.
`ifndef PSE_SEQ_DEFS_VH
`define PSE_SEQ_DEFS_VH

// Register offsets on the serial bus
`define OFS_DET_EVT    8'h04
`define OFS_FLT_EVT    8'h06
`define OFS_DISC_EVT   8'h08
`define OFS_STAT0      8'h0c
`define OFS_STAT3      8'h0f
`define OFS_PWR_STAT   8'h10
`define OFS_MODE       8'h12
`define OFS_DISC_EN    8'h13
`define OFS_DC_EN      8'h14
`define OFS_DC_RESTART 8'h18
`define OFS_PWR_TRIG   8'h19
`define OFS_RST_TRIG   8'h1a

// Reset-trigger bit for the whole device
`define RST_ALL_BIT    4

// Operating mode encoding, two bits per port
`define MODE_SHUT      2'h0
`define MODE_MANUAL    2'h1
`define MODE_SEMI      2'h2
`define MODE_AUTO      2'h3

// Defaults that follow the mode strap
`define MODE_ALL_AUTO  8'hff
`define DC_EN_ALL      8'hff
`define DISC_EN_ALL    4'hf
`define LOAD_DLY       2'h3

// Serial device address: upper three bits fixed, lower four from pins
`define DEV_ADDR_HI    3'h2

// Detect status codes
`define DET_UNKNOWN    3'h0
`define DET_SHORT      3'h1
`define DET_LOW        3'h3
`define DET_GOOD       3'h4
`define DET_HIGH       3'h5
`define DET_OPEN       3'h6

// Detection slope limits, voltage codes of 25 mV per 100 uA step (1k = 4)
`define DV_SHORT_MAX   11'h004
`define DV_GOOD_MIN    11'h044
`define DV_GOOD_MAX    11'h074
`define V_OPEN_MIN     10'h3e8

// Class current limits in mA (upper bounds, exclusive except the inclusive class 4 maximum)
`define CUR_CLS0_END   6'h08
`define CUR_CLS1_END   6'h10
`define CUR_CLS2_END   6'h19
`define CUR_CLS3_END   6'h23
`define CUR_CLS4_MAX   6'h2d
`define CLS_OVER       3'h6

// Timing
`define CLK_PER_MS     200000
`define DET_POINT_MS   100
`define DET_REPEAT_MS  320
`define CLASS_MS       10
`define CNT_W          25

`endif

// ### hdl/sync2.v
// Two-flop synchroniser for pins from outside the core clock domain.
// Assumes inputs are slow levels; the first flop feeds only the second.
`timescale 1ns/1ps
module sync2 #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         ce_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta;

  always @(posedge core_clk_i)
  begin
    if (ce_i)
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sync2

// ### hdl/port_seq.v
// One port: detection, classification and power enable sequencing.
// Assumes the front end gives a settled voltage and current every cycle.
`timescale 1ns/1ps
`include "pse_defs.vh"
module port_seq #(
  parameter [`CNT_W-1:0] POINT_CYC = `DET_POINT_MS * `CLK_PER_MS,
  parameter [`CNT_W-1:0] GAP_CYC   = (`DET_REPEAT_MS - 2 * `DET_POINT_MS) * `CLK_PER_MS,
  parameter [`CNT_W-1:0] CLASS_CYC = `CLASS_MS * `CLK_PER_MS
) (
  input  wire       core_clk_i,
  input  wire       rst_b_i,
  input  wire       ce_i,
  input  wire [1:0] mode_i,
  input  wire       det_en_i,
  input  wire       cls_en_i,
  input  wire       det_go_i,
  input  wire       cls_go_i,
  input  wire       on_i,
  input  wire       off_i,
  input  wire       fault_i,
  input  wire       clear_i,
  input  wire [9:0] volt_i,
  input  wire [5:0] curr_i,
  output wire       probe_o,
  output wire       probe_step_o,
  output wire       class_drive_o,
  output reg        power_o,
  output reg  [2:0] det_code_o,
  output reg  [2:0] cls_code_o,
  output reg        det_done_o,
  output reg        cls_done_o
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PT1  = 3'h1;
  localparam [2:0] S_PT2  = 3'h2;
  localparam [2:0] S_CLS  = 3'h3;
  localparam [2:0] S_GAP  = 3'h4;

  reg [2:0]         st;
  reg [`CNT_W-1:0]  cnt;
  reg [9:0]         v1;
  reg [2:0]         next_det;
  reg [2:0]         next_cls;
  wire [10:0]       dv = {1'b0, volt_i} - {1'b0, v1};

  wire manual = (mode_i == `MODE_MANUAL);
  wire autom  = (mode_i == `MODE_AUTO);
  wire looped = (mode_i == `MODE_SEMI) | autom;
  wire det_ok = det_en_i & ~power_o & (mode_i != `MODE_SHUT);
  wire cls_ok = cls_en_i & ~power_o & (mode_i != `MODE_SHUT);

  assign probe_o       = (st == S_PT1) | (st == S_PT2);
  assign probe_step_o  = (st == S_PT2);
  assign class_drive_o = (st == S_CLS);

  // Slope of the two points removes diode offset and leakage
  always @*
  begin
    next_det = `DET_HIGH;
    if (volt_i >= `V_OPEN_MIN)
      next_det = `DET_OPEN;
    else if (dv[10] || dv <= `DV_SHORT_MAX)
      next_det = `DET_SHORT;
    else if (dv < `DV_GOOD_MIN)
      next_det = `DET_LOW;
    else if (dv <= `DV_GOOD_MAX)
      next_det = `DET_GOOD;
  end

  // Gaps between class bands fall to the band below
  always @*
  begin
    next_cls = `CLS_OVER;
    if (curr_i < `CUR_CLS0_END)
      next_cls = 3'h0;
    else if (curr_i < `CUR_CLS1_END)
      next_cls = 3'h1;
    else if (curr_i < `CUR_CLS2_END)
      next_cls = 3'h2;
    else if (curr_i < `CUR_CLS3_END)
      next_cls = 3'h3;
    else if (curr_i <= `CUR_CLS4_MAX)
      next_cls = 3'h4;
  end

  always @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      st         <= S_IDLE;
      cnt        <= {`CNT_W{1'b0}};
      v1         <= 10'h000;
      power_o    <= 1'b0;
      det_code_o <= `DET_UNKNOWN;
      cls_code_o <= 3'h0;
      det_done_o <= 1'b0;
      cls_done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      det_done_o <= 1'b0;
      cls_done_o <= 1'b0;
      cnt        <= cnt + 1'b1;
      if (clear_i)
      begin
        // Power drops first, status clears once it is off
        st      <= S_IDLE;
        cnt     <= {`CNT_W{1'b0}};
        power_o <= 1'b0;
        if (!power_o)
        begin
          det_code_o <= `DET_UNKNOWN;
          cls_code_o <= 3'h0;
        end
      end
      else
      begin
        case (st)
          S_IDLE:
          begin
            cnt <= {`CNT_W{1'b0}};
            if (det_ok && (looped || det_go_i))
              st <= S_PT1;
            else if (manual && cls_go_i && cls_ok)
              st <= S_CLS;
          end
          S_PT1:
          begin
            if (!det_ok)
              st <= S_IDLE;
            else if (manual && det_go_i)
              cnt <= {`CNT_W{1'b0}};
            else if (cnt == POINT_CYC - 1'b1)
            begin
              v1  <= volt_i;
              cnt <= {`CNT_W{1'b0}};
              st  <= S_PT2;
            end
          end
          S_PT2:
          begin
            if (!det_ok)
              st <= S_IDLE;
            else if (manual && det_go_i)
            begin
              cnt <= {`CNT_W{1'b0}};
              st  <= S_PT1;
            end
            else if (cnt == POINT_CYC - 1'b1)
            begin
              det_code_o <= next_det;
              det_done_o <= 1'b1;
              cnt        <= {`CNT_W{1'b0}};
              if (manual)
                st <= S_IDLE;
              else if (next_det == `DET_GOOD && cls_en_i)
                st <= S_CLS;
              else if (next_det == `DET_GOOD && autom)
              begin
                power_o <= 1'b1;
                st      <= S_IDLE;
              end
              else
                st <= S_GAP;
            end
          end
          S_CLS:
          begin
            if (!cls_ok)
              st <= S_IDLE;
            else if (cnt == CLASS_CYC - 1'b1)
            begin
              cls_code_o <= next_cls;
              cls_done_o <= 1'b1;
              cnt        <= {`CNT_W{1'b0}};
              if (autom)
              begin
                power_o <= 1'b1;
                st      <= S_IDLE;
              end
              else if (looped)
                st <= S_GAP;
              else
                st <= S_IDLE;
            end
          end
          S_GAP:
          begin
            if (!det_ok)
              st <= S_IDLE;
            else if (cnt == GAP_CYC - 1'b1)
              st <= S_IDLE;
          end
          default:
            st <= S_IDLE;
        endcase
        if (on_i)
          power_o <= 1'b1;
        if (fault_i || off_i)
          power_o <= 1'b0;
      end
    end
  end
endmodule // port_seq

// ### sim/host_i2c_model.sv
// Serial host model: drives clock and data, reads the data wire.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module host_i2c_model #(
  parameter [6:0] DEV = 7'h25
) (
  output reg       scl_o,
  output reg       sda_o,
  input  wire      sda_i,
  output reg [7:0] nacks
);
  reg [7:0] q;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    nacks = 8'h00;
  end
  // Data moves late in the low half, after the ack release
  task bit_x(input b, output r);
    begin
      #20 sda_o = b;
      #12 scl_o = 1'b1;
      #16 r = sda_i;
      #16 scl_o = 1'b0;
    end
  endtask
  task byte_x(input [7:0] d, input chk, output [7:0] v);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        bit_x(d[i], r);
        v = {v[6:0], r};
      end
      bit_x(1'b1, r);
      if (chk && r) nacks = nacks + 8'h01;
    end
  endtask
  task start_x;
    begin
      sda_o = 1'b1;
      #16 scl_o = 1'b1;
      #16 sda_o = 1'b0;
      #16 scl_o = 1'b0;
    end
  endtask
  task stop_x;
    begin
      #20 sda_o = 1'b0;
      #12 scl_o = 1'b1;
      #16 sda_o = 1'b1;
      #16;
    end
  endtask
  task wr(input [7:0] p, input [7:0] d);
    begin
      start_x;
      byte_x({DEV, 1'b0}, 1'b1, q);
      byte_x(p, 1'b1, q);
      byte_x(d, 1'b1, q); // Ones only act on trigger offsets
      stop_x;
    end
  endtask
  task rd(input [7:0] p, output [7:0] d);
    begin
      start_x;
      byte_x({DEV, 1'b0}, 1'b1, q);
      byte_x(p, 1'b1, q);
      start_x;
      byte_x({DEV, 1'b1}, 1'b1, q);
      byte_x(8'hff, 1'b0, d);
      stop_x;
    end
  endtask
endmodule // host_i2c_model

// ### sim/pse_mode_seq_chk.sv
// Port-level checks for the PSE mode sequencer.
// Assumes ce_i stays high; bound to the top module.
`timescale 1ns/1ps
module pse_mode_seq_chk #(
  parameter int POINT_CYC = 20,
  parameter int CLASS_CYC = 8
) (
  input wire        core_clk_i,
  input wire        rst_b_i,
  input wire        ce_i,
  input wire        sda_oe_o,
  input wire [3:0]  startup_timeout_i,
  input wire [3:0]  overcurrent_timeout_i,
  input wire [3:0]  port_probe_pin_o,
  input wire [3:0]  probe_step_o,
  input wire [3:0]  class_drive_o,
  input wire [3:0]  power_on_o
);
  localparam int DET_HI = 2 * POINT_CYC + 1;
  localparam int CLS_HI = CLASS_CYC + 1;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rst; $rose(rst_b_i) |-> power_on_o == 4'h0 && !sda_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs live after reset");
  property p_stt; ce_i && |startup_timeout_i |=> (power_on_o & $past(startup_timeout_i)) == 0;
  endproperty
  a_stt: assert property (p_stt) else $error("power kept after startup");
  property p_ovc;
    ce_i && |overcurrent_timeout_i |=> (power_on_o & $past(overcurrent_timeout_i)) == 0;
  endproperty
  a_ovc: assert property (p_ovc) else $error("power kept after overcurrent");
  property p_excl; (port_probe_pin_o & class_drive_o) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("probe with class drive");
  property p_step; (probe_step_o & ~port_probe_pin_o) == 4'h0; endproperty
  a_step: assert property (p_step) else $error("second point without probe");
  property p_pt1; $rose(probe_step_o[3]) |-> $past(port_probe_pin_o[3], POINT_CYC); endproperty
  a_pt1: assert property (p_pt1) else $error("first point length wrong");
  property p_det; $rose(port_probe_pin_o[3]) |-> ##[1:DET_HI] !port_probe_pin_o[3]; endproperty
  a_det: assert property (p_det) else $error("detection too long");
  property p_cls; $rose(class_drive_o[3]) |-> ##[1:CLS_HI] !class_drive_o[3]; endproperty
  a_cls: assert property (p_cls) else $error("classification too long");
  property p_dpw; (port_probe_pin_o & power_on_o & $past(power_on_o)) == 4'h0; endproperty
  a_dpw: assert property (p_dpw) else $error("probing a powered port");
  property p_cpw; (class_drive_o & power_on_o & $past(power_on_o)) == 4'h0; endproperty
  a_cpw: assert property (p_cpw) else $error("classifying a powered port");
endmodule // pse_mode_seq_chk
bind pse_mode_seq pse_mode_seq_chk #(.POINT_CYC(POINT_CYC), .CLASS_CYC(CLASS_CYC))
  pse_mode_seq_chk_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .sda_oe_o(sda_oe_o), .startup_timeout_i(startup_timeout_i),
  .overcurrent_timeout_i(overcurrent_timeout_i), .port_probe_pin_o(port_probe_pin_o),
  .probe_step_o(probe_step_o), .class_drive_o(class_drive_o), .power_on_o(power_on_o));

// ### sim/pse_mode_seq_test.sv
// Self-checking bench for the PSE mode sequencer with a serial host model.
// Assumes short point, gap and class counts.
`timescale 1ns/1ps
module pse_mode_seq_test;
  reg         core_clk_i = 1'b0;
  reg         rst_b_i = 1'b0, strap = 1'b1;
  reg  [3:0]  stt = 4'h0, ovc = 4'h0, dis = 4'h0;
  reg  [39:0] volt = 40'h0;
  wire        scl, host_sda, sda_o, sda_oe_o;
  wire [7:0]  nacks;
  wire [3:0]  probe, step, cdrv, pwr;
  // Open-drain wire with pull-up
  wire        sda = host_sda & ~(sda_oe_o & ~sda_o);
  integer     n_errors = 0, checks_done = 0, k;
  reg  [7:0]  v;
  // Port 2 shows a short, the rest a good slope
  wire [39:0] dv = {10'h050, 10'h000, 10'h050, 10'h050};
  pse_mode_seq #(.POINT_CYC(20), .GAP_CYC(10), .CLASS_CYC(8)) pse_mode_seq_i (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_addr_i(4'h5), .mode_strap_i(strap),
    .startup_timeout_i(stt), .overcurrent_timeout_i(ovc), .disconnect_i(dis),
    .meas_volt_i(volt), .meas_curr_i({6'h14, 6'h02, 6'h02, 6'h02}),
    .port_probe_pin_o(probe), .probe_step_o(step), .class_drive_o(cdrv), .power_on_o(pwr));
  host_i2c_model host_i2c_model_i (.scl_o(scl), .sda_o(host_sda), .sda_i(sda), .nacks(nacks));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i)
    for (k = 0; k < 4; k = k + 1)
      volt[10*k +: 10] <= step[k] ? 10'h0c8 + dv[10*k +: 10] : 10'h0c8;
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wait_pw(input [3:0] e);
    integer i;
    begin
      for (i = 0; i < 400 && pwr !== e; i = i + 1)
        @(negedge core_clk_i);
      chk({4'h0, pwr}, {4'h0, e});
    end
  endtask
  task t_auto;
    begin
      host_i2c_model_i.rd(8'h12, v);
      chk(v, 8'hff);
      wait_pw(4'hb);
    end
  endtask
  // One fault source at a time; others keep power
  task t_fault;
    begin
      @(negedge core_clk_i) ovc = 4'h1;
      @(negedge core_clk_i) ovc = 4'h0;
      chk({4'h0, pwr}, 8'h0a);
      stt = 4'h2;
      @(negedge core_clk_i) stt = 4'h0;
      chk({4'h0, pwr}, 8'h08);
      dis = 4'h8;
      @(negedge core_clk_i) dis = 4'h0;
      chk({4'h0, pwr}, 8'h00);
      wait_pw(4'hb);
    end
  endtask
  task t_off;
    begin
      host_i2c_model_i.wr(8'h19, 8'h20);
      chk({4'h0, pwr}, 8'h09);
      host_i2c_model_i.rd(8'h19, v);
      chk(v, 8'h00);
    end
  endtask
  task t_shut;
    begin
      host_i2c_model_i.wr(8'h12, 8'h00);
      chk({4'h0, pwr}, 8'h00);
      host_i2c_model_i.rd(8'h0f, v);
      chk(v, 8'h00);
    end
  endtask
  // Ports 0-2 manual, port 3 semiauto
  task t_manual;
    begin
      host_i2c_model_i.wr(8'h12, 8'h95);
      host_i2c_model_i.rd(8'h12, v);
      chk(v, 8'h95);
      host_i2c_model_i.wr(8'h18, 8'h8e);
      host_i2c_model_i.wr(8'h19, 8'h01);
      chk({4'h0, pwr}, 8'h01);
      host_i2c_model_i.rd(8'h0d, v);
      chk(v, 8'h04);
      host_i2c_model_i.rd(8'h0e, v);
      chk(v, 8'h01);
      host_i2c_model_i.rd(8'h0f, v);
      chk(v, 8'h24);
      chk({4'h0, pwr}, 8'h01);
    end
  endtask
  task t_rstall;
    begin
      @(negedge core_clk_i) strap = 1'b0;
      host_i2c_model_i.wr(8'h1a, 8'h10);
      chk({4'h0, pwr}, 8'h00);
      host_i2c_model_i.rd(8'h12, v);
      chk(v, 8'h00);
      chk(nacks, 8'h01);
    end
  endtask
  task end_of_test;
    begin
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    t_auto;
    t_fault;
    t_off;
    t_shut;
    t_manual;
    t_rstall;
    end_of_test;
  end
  // Ample span for every transfer
  initial
  begin
    #300000;
    n_errors = n_errors + 1;
    end_of_test;
  end
endmodule // pse_mode_seq_test
